// [dv/cdl_codec_link_tb.sv]
/*
 Self-checking bench of the codec link block: register reads and writes travel as link frames
 through the controller model, and every returned input frame is compared field by field.
 Assumes the package constants describe the stored register table.
*/
`timescale 1ns/1ps
module cdl_codec_link_tb;
    import cdl_pkg::*;

    // ------------------------------------------------------------------
    // Signals and state
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic bitClk;
    logic syncIn;
    logic sdataOut;
    logic sdataIn;
    logic externalAmpOff;
    logic [3:0] analogReady = 4'hf;
    logic [17:0] recLeft = 18'h0;
    logic [17:0] recRight = 18'h0;
    cdl_pd_s powerCtrl;
    cdl_regs_t ctrlRegs;
    int failures = 0;
    int num_checks = 0;
    logic [6:0] echoIdx = 7'h00;
    logic [15:0] echoData = 16'h0000;
    logic rdPend = 1'b0;
    logic adcOk = 1'b1;
    logic dacOk = 1'b1;

    always #10 clock = ~clock;

    cdl_codec_link u_dut (
        .clock(clock), .arst_n(arst_n), .bitClk(bitClk), .syncIn(syncIn),
        .sdataOut(sdataOut), .analogReady(analogReady), .recLeft(recLeft),
        .recRight(recRight), .sdataIn(sdataIn), .externalAmpOff(externalAmpOff),
        .powerCtrl(powerCtrl), .ctrlRegs(ctrlRegs)
    );

    cdl_ctrl_model u_ctrl (
        .bitClk(bitClk), .syncIn(syncIn), .sdataOut(sdataOut), .sdataIn(sdataIn)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One link frame; the returned input frame is judged against the previous command.
    task automatic frame(input logic [15:0] tag, input logic rd, input logic [6:0] idx,
                         input logic [15:0] wd, input logic [15:0] rdExp);
        logic [255:0] ob;
        logic [255:0] ib;
        cdl_frame_s f;
        @(posedge clock);
        #2;
        recLeft = {2'b10, wd ^ {9'h0, idx}};
        recRight = {2'b01, ~wd};
        ob = {tag, rd, idx, 12'h000, wd, 4'h0, 200'h0};
        u_ctrl.run_frame(ob, ib);
        f = ib;
        chk(32'(f.tag), {16'h0, 2'b11, rdPend, adcOk, adcOk, 11'h000});
        chk(32'(f.slot1), {12'h0, 1'b0, echoIdx, ~dacOk, ~dacOk, 1'b0, 4'hf, 5'h00});
        chk(32'(f.slot2), {12'h0, echoData, 4'h0});
        chk(32'(f.slot3), {12'h0, recLeft, 2'b00});
        chk(32'(f.slot4), {12'h0, recRight, 2'b00});
        chk({31'h0, f.quiet !== 160'h0}, 32'h0);
        rdPend = rd;
        echoIdx = rd ? idx : 7'h00;
        echoData = rd ? rdExp : 16'h0000;
    endtask : frame

    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        frame(16'he000, 1'b0, idx, d, 16'h0000);
    endtask : wr

    task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
        frame(16'hc000, 1'b1, idx, 16'h0000, exp);
    endtask : rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        #1900000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clock);
        #2;
        arst_n = 1'b1;
        for (int i = 0; i < CDL_NREG; i++) begin
            chk(32'(ctrlRegs[i]), 32'(CDL_REG_DEF[i]));
        end
        rd(CDL_IDX_RESET, CDL_CAPS_WORD);
        rd(CDL_IDX_SPATIAL, CDL_SPATIAL_WORD);
        wr(CDL_IDX_SPATIAL, 16'h0000);
        rd(CDL_IDX_SPATIAL, CDL_SPATIAL_WORD);
        rd(7'h24, 16'h0000);
        // The power register is left out: setting its link bit would clear tag bit 15 of every returned frame.
        for (int i = 0; i < CDL_SLOT_POWER; i++) begin
            wr(CDL_REG_IDX[i], 16'hffff);
        end
        for (int i = 0; i < CDL_SLOT_POWER; i++) begin
            rd(CDL_REG_IDX[i], CDL_REG_MASK[i]);
        end
        rd(CDL_IDX_POWER, 16'h000f);
        wr(CDL_IDX_POWER, 16'h8200);
        dacOk = 1'b0;
        chk(32'(powerCtrl), 32'h82);
        chk(32'(externalAmpOff), 32'h1);
        rd(CDL_IDX_POWER, 16'h820d);
        // The answer is built at the next frame start, so the readiness change made after this read already shows in it.
        rd(CDL_IDX_POWER, 16'h8204);
        analogReady = 4'h6;
        repeat (10) @(posedge clock);
        adcOk = 1'b0;
        wr(CDL_IDX_RESET, 16'h1234);
        dacOk = 1'b1;
        for (int i = 0; i < CDL_NREG; i++) begin
            chk(32'(ctrlRegs[i]), 32'(CDL_REG_DEF[i]));
        end
        rd(CDL_IDX_POWER, 16'h0006);
        frame(16'h8000, 1'b0, 7'h00, 16'h0000, 16'h0000);
        frame(16'h8000, 1'b0, 7'h00, 16'h0000, 16'h0000);
        end_sim();
    end
endmodule : cdl_codec_link_tb

// [dv/cdl_ctrl_model.sv]
/*
 Behavioural model of the link controller: makes the bit clock and frame sync, shifts a
 256-bit output frame out and captures the 256-bit input frame.
 Assumes the caller starts each frame shortly after a system clock edge.
*/
`timescale 1ns/1ps
module cdl_ctrl_model (
    output logic bitClk,
    output logic syncIn,
    output logic sdataOut,
    input wire logic sdataIn
);
    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    initial begin
        bitClk = 1'b0;
        syncIn = 1'b0;
        sdataOut = 1'b0;
    end

    // The bit clock stands still between frames, and the data line is inverted there so a
    // device that latches outside a frame sees a changed value rather than a lucky match.
    task automatic run_frame(input logic [255:0] ob, output logic [255:0] ib);
        for (int p = 0; p < 256; p++) begin
            bitClk = 1'b1;
            syncIn = (p < 16);
            sdataOut = ob[255 - p];
            #80;
            ib[255 - p] = sdataIn;
            bitClk = 1'b0;
            #80;
        end
        sdataOut = ~sdataOut;
    endtask : run_frame
endmodule : cdl_ctrl_model

// [pkg/cdl_pkg.sv]
/*
 Shared constants, register table and carrier types of the codec link input-frame builder and its
 control register bank. Assumes a single 50 MHz system clock and an external link bit clock.
*/
// Behaviour
// - Input slot 1 echoes requested index, bit19 low.
// - Slot 1 bits 11,10 request slots 3,4.
// - Slot 1 bits 8..5 request slots 6..9.
// - Slot 1 bits 9, 4..0 always zero.
// - Slot 2 returns read data, else zero.
// - Slot 3 carries left record sample.
// - Slot 4 carries right record sample.
// - Slots 5 to 12 always zero.
// - Reset register write defaults all; reads caps.
// - Line output volume fields, mute, default.
// - Headphone volume behaves like line output.
// - Single output volume five bits, muted default.
// - Beep volume four bits, unmuted default.
// - Mixer input gains, mute, mono/stereo defaults.
// - Microphone register bit 6 adds boost.
// - Record source select, two 3-bit fields.
// - Record gain four bits per channel, muted.
// - Miscellaneous path register five control bits.
// - Spatial enhancement register reads fixed value.
// - Power register: four status, eight controls.
// - Powerdown controls act on their subsections.
// - Ready bits ADC, DAC, mixers, reference order.
// - Controls bits 8..14, amplifier bit 15.
package cdl_pkg;

    // ------------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------------
    localparam logic [7:0] CDL_LAST_POS = 8'hff;
    localparam logic [7:0] CDL_CMD_LAST_POS = 8'h37;
    localparam logic [7:0] CDL_QUIET_POS = 8'h60;
    localparam int CDL_CMD_BITS = 56;
    localparam int CDL_RW_BIT = 19;

    // ------------------------------------------------------------------
    // Register indices and fixed read values
    // ------------------------------------------------------------------
    localparam logic [6:0] CDL_IDX_RESET = 7'h00;
    localparam logic [6:0] CDL_IDX_SPATIAL = 7'h22;
    localparam logic [6:0] CDL_IDX_POWER = 7'h26;
    localparam logic [15:0] CDL_CAPS_WORD = 16'h0d50;
    localparam logic [15:0] CDL_SPATIAL_WORD = 16'h0101;
    localparam int CDL_NREG = 15;
    localparam int CDL_SLOT_LINE = 0;
    localparam int CDL_SLOT_POWER = 14;
    localparam logic [15:0] CDL_LINE_DEF = 16'h8000;

    // Index, default and writable-bit mask of every stored register.
    localparam logic [6:0] CDL_REG_IDX [CDL_NREG] = '{
        7'h02, 7'h04, 7'h06, 7'h0a, 7'h0c, 7'h0e, 7'h10, 7'h12,
        7'h14, 7'h16, 7'h18, 7'h1a, 7'h1c, 7'h20, 7'h26
    };
    localparam logic [15:0] CDL_REG_DEF [CDL_NREG] = '{
        16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h8008, 16'h8008, 16'h8808, 16'h8808,
        16'h8808, 16'h8808, 16'h8808, 16'h0000, 16'h8000, 16'h0000, 16'h0000
    };
    localparam logic [15:0] CDL_REG_MASK [CDL_NREG] = '{
        16'h9f1f, // Line output volume, two 5-bit fields and one mute.
        16'h9f1f, // Headphone volume, same layout as line output.
        16'h801f, // Single output volume, one 5-bit field.
        16'h801e, // Beep volume, 4-bit field in bits 4..1.
        16'h801f, // Mono mixer input.
        16'h805f, // Microphone input with the boost bit.
        16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, // Stereo mixer inputs.
        16'h0707, // Left and right record source.
        16'h8f0f, // Record gain, 4-bit fields and one mute.
        16'ha380, // Bypass, enhance, single-out source, mic choice, loopback.
        16'hff00  // Powerdown controls; status bits are merged at read time.
    };

    // ------------------------------------------------------------------
    // Powerdown field positions
    // ------------------------------------------------------------------
    localparam int CDL_PD_ADC = 8;
    localparam int CDL_PD_DAC = 9;
    localparam int CDL_PD_MIX = 10;
    localparam int CDL_PD_MIXREF = 11;
    localparam int CDL_PD_LINK = 12;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef logic [CDL_NREG-1:0][15:0] cdl_regs_t;

    typedef struct packed {
        logic externalAmpOff;
        logic headphoneAmpPowerdown;
        logic internalClockDisable;
        logic linkInterfacePowerdown;
        logic mixerAndRefPowerdown;
        logic mixerPowerdownRefOn;
        logic dacPathPowerdown;
        logic adcPathPowerdown;
    } cdl_pd_s;

    typedef struct packed {
        logic [15:0] tag;
        logic [19:0] slot1;
        logic [19:0] slot2;
        logic [19:0] slot3;
        logic [19:0] slot4;
        logic [7:0][19:0] quiet;
    } cdl_frame_s;

endpackage : cdl_pkg

// [verilog/cdl_codec_link.sv]
/*
 Codec link device logic: samples the link bit clock, frame sync and controller data with the
 system clock, decodes register reads and writes, keeps the control register bank and builds the
 256-bit input frame shifted out on the serial data line.
 Assumes the bit clock is at least six system clocks long so both of its edges are seen.
*/
`timescale 1ns/1ps
module cdl_codec_link (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic bitClk,
    input wire logic syncIn,
    input wire logic sdataOut,
    input wire logic [3:0] analogReady,
    input wire logic [17:0] recLeft,
    input wire logic [17:0] recRight,
    output logic sdataIn,
    output logic externalAmpOff,
    output cdl_pkg::cdl_pd_s powerCtrl,
    output cdl_pkg::cdl_regs_t ctrlRegs
);
    import cdl_pkg::*;

    typedef enum logic [1:0] {
        CDL_IDLE = 2'b01,
        CDL_RUN = 2'b10
    } cdl_state_e;

    // ------------------------------------------------------------------
    // Pin synchronisers and link edges
    // ------------------------------------------------------------------
    logic [6:0] pinMeta_r;
    logic [6:0] pinSync_r;
    logic bcPrev_r;
    logic syncAtRise_r;
    logic bcRise;
    logic bcFall;
    logic syncRise;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_r <= 7'h00;
            pinSync_r <= 7'h00;
        end else begin
            pinMeta_r <= {analogReady, sdataOut, syncIn, bitClk};
            pinSync_r <= pinMeta_r;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bcPrev_r <= 1'b0;
            syncAtRise_r <= 1'b0;
        end else begin
            bcPrev_r <= pinSync_r[0];
            if (bcRise) begin
                syncAtRise_r <= pinSync_r[1];
            end
        end
    end

    assign bcRise = pinSync_r[0] & ~bcPrev_r;
    assign bcFall = ~pinSync_r[0] & bcPrev_r;
    assign syncRise = bcRise & pinSync_r[1] & ~syncAtRise_r;

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    logic [15:0] regs_r [CDL_NREG];
    logic wrStrobe_r;
    logic [6:0] wrIdx_r;
    logic [15:0] wrData_r;
    logic regReset;
    logic [15:0] pwrReg;
    logic [3:0] statusBits;

    assign regReset = wrStrobe_r && (wrIdx_r == CDL_IDX_RESET);

    for (genvar g = 0; g < CDL_NREG; g++) begin : g_reg
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                regs_r[g] <= CDL_REG_DEF[g];
            end else if (regReset) begin
                regs_r[g] <= CDL_REG_DEF[g];
            end else if (wrStrobe_r && (wrIdx_r == CDL_REG_IDX[g])) begin
                // Bits outside the mask keep their default so reserved bits read zero.
                regs_r[g] <= (wrData_r & CDL_REG_MASK[g]) | (CDL_REG_DEF[g] & ~CDL_REG_MASK[g]);
            end
        end
        assign ctrlRegs[g] = regs_r[g];
    end

    assign pwrReg = regs_r[CDL_SLOT_POWER];

    // A subsection only reports ready while its own powerdown control is clear.
    assign statusBits[0] = pinSync_r[3] & ~pwrReg[CDL_PD_ADC];
    assign statusBits[1] = pinSync_r[4] & ~pwrReg[CDL_PD_DAC];
    assign statusBits[2] = pinSync_r[5] & ~pwrReg[CDL_PD_MIX] & ~pwrReg[CDL_PD_MIXREF];
    assign statusBits[3] = pinSync_r[6] & ~pwrReg[CDL_PD_MIXREF];

    assign powerCtrl = cdl_pd_s'(pwrReg[15:8]);
    assign externalAmpOff = pwrReg[15];

    function automatic logic [15:0] readValue(input logic [6:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == CDL_IDX_RESET) begin
            v = CDL_CAPS_WORD;
        end
        if (idx == CDL_IDX_SPATIAL) begin
            v = CDL_SPATIAL_WORD;
        end
        for (int i = 0; i < CDL_NREG; i++) begin
            if (idx == CDL_REG_IDX[i]) begin
                v = regs_r[i];
            end
        end
        if (idx == CDL_IDX_POWER) begin
            v = pwrReg | {12'h000, statusBits};
        end
        return v;
    endfunction : readValue

    // ------------------------------------------------------------------
    // Command receiver
    // ------------------------------------------------------------------
    cdl_state_e state_r;
    logic [7:0] pos_r;
    logic [CDL_CMD_BITS-2:0] rxShift_r;
    logic [CDL_CMD_BITS-1:0] rxFull;
    logic cmdDone;
    logic readPend_r;
    logic [6:0] readIdx_r;
    logic frameStart;

    assign rxFull = {rxShift_r, pinSync_r[2]};
    assign cmdDone = bcFall && (state_r == CDL_RUN) && (pos_r == CDL_CMD_LAST_POS);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxShift_r <= '0;
        end else if (bcFall && (state_r == CDL_RUN)) begin
            rxShift_r <= rxFull[CDL_CMD_BITS-2:0];
        end
    end

    // Tag bit 14 marks a command address, bit 13 the write data.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrStrobe_r <= 1'b0;
            wrIdx_r <= 7'h00;
            wrData_r <= 16'h0000;
        end else begin
            wrStrobe_r <= cmdDone && rxFull[54] && rxFull[53] && !rxFull[20 + CDL_RW_BIT];
            if (cmdDone) begin
                wrIdx_r <= rxFull[38:32];
                wrData_r <= rxFull[19:4];
            end
        end
    end

    // The request set wins over the clear taken by a frame start.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            readPend_r <= 1'b0;
            readIdx_r <= 7'h00;
        end else if (cmdDone && rxFull[54] && rxFull[20 + CDL_RW_BIT]) begin
            readPend_r <= 1'b1;
            readIdx_r <= rxFull[38:32];
        end else if (frameStart) begin
            readPend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Input frame builder
    // ------------------------------------------------------------------
    cdl_frame_s frameNxt;
    logic [255:0] txShift_r;
    logic sdataIn_r;

    // Frame contents are rebuilt from live state at each frame start, so status is never stale.
    always_comb begin
        frameNxt.tag = {~pwrReg[CDL_PD_LINK], 1'b1, readPend_r, statusBits[0], statusBits[0],
                        11'h000};
        frameNxt.slot1 = {1'b0, (readPend_r ? readIdx_r : 7'h00),
                          {2{~statusBits[1]}},
                          1'b0, 4'hf,
                          5'h00};
        frameNxt.slot2 = readPend_r ? {readValue(readIdx_r), 4'h0} : 20'h00000;
        frameNxt.slot3 = {recLeft, 2'b00};
        frameNxt.slot4 = {recRight, 2'b00};
        frameNxt.quiet = '0;
    end

    // A sync rise before the previous frame ended starts no frame; it ends the running one and drives the line low.
    assign frameStart = syncRise && ((state_r == CDL_IDLE) || (pos_r == CDL_LAST_POS));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= CDL_IDLE;
            pos_r <= 8'h00;
            txShift_r <= '0;
            sdataIn_r <= 1'b0;
        end else if (frameStart) begin
            state_r <= CDL_RUN;
            pos_r <= 8'h00;
            txShift_r <= frameNxt;
            sdataIn_r <= frameNxt.tag[15];
        end else if (bcRise) begin
            case (state_r)
                CDL_RUN: begin
                    if (syncRise || (pos_r == CDL_LAST_POS)) begin
                        state_r <= CDL_IDLE;
                        sdataIn_r <= 1'b0;
                    end else begin
                        pos_r <= pos_r + 8'h01;
                        txShift_r <= {txShift_r[254:0], 1'b0};
                        sdataIn_r <= txShift_r[254];
                    end
                end
                CDL_IDLE: begin
                    sdataIn_r <= 1'b0;
                end
                default: begin
                    state_r <= CDL_IDLE;
                    sdataIn_r <= 1'b0;
                end
            endcase
        end
    end

    assign sdataIn = sdataIn_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_index_echo: assert property (frameStart && readPend_r |-> ##1
        txShift_r[238:232] == $past(readIdx_r))
        else $error("echoed index differs from request");
    a_slot1_zero: assert property (frameStart |-> frameNxt.slot1[19] == 1'b0
        && frameNxt.slot1[9] == 1'b0 && frameNxt.slot1[4:0] == 5'h00)
        else $error("reserved slot 1 bits not zero");
    a_slot_request: assert property (frameStart |-> frameNxt.slot1[8:5] == 4'hf
        && frameNxt.slot1[11] == frameNxt.slot1[10])
        else $error("slot request bits wrong");
    a_data_idle: assert property (frameStart && !readPend_r |-> ##1
        txShift_r[219:200] == 20'h00000)
        else $error("status data not zero without request");
    a_pend_clear: assert property (frameStart && readPend_r && !cmdDone |=> !readPend_r)
        else $error("read echo repeated");
    a_rec_left: assert property (frameStart |-> ##1
        txShift_r[199:180] == {$past(recLeft), 2'b00})
        else $error("left record slot wrong");
    a_rec_right: assert property (frameStart |-> ##1
        txShift_r[179:160] == {$past(recRight), 2'b00})
        else $error("right record slot wrong");
    a_quiet_slots: assert property ((state_r == CDL_RUN) && (pos_r >= CDL_QUIET_POS) |->
        !sdataIn_r)
        else $error("data driven in an unused slot");
    a_reg_reset: assert property (regReset |=> regs_r[CDL_SLOT_LINE] == CDL_LINE_DEF
        && readValue(CDL_IDX_RESET) == CDL_CAPS_WORD)
        else $error("register reset not applied");
    a_write_back: assert property (wrStrobe_r && !regReset && wrIdx_r == CDL_IDX_POWER |=>
        (readValue(CDL_IDX_POWER) >> 8) == {8'h00, $past(wrData_r[15:8])})
        else $error("powerdown controls not read back");
    a_spatial_fixed: assert property (wrStrobe_r && wrIdx_r == CDL_IDX_SPATIAL |=>
        readValue(CDL_IDX_SPATIAL) == CDL_SPATIAL_WORD)
        else $error("spatial register changed");
    a_amp_pin: assert property (wrStrobe_r && !regReset && wrIdx_r == CDL_IDX_POWER |-> ##1
        externalAmpOff == $past(wrData_r[15]))
        else $error("amplifier pin not following control");

    c_read_frame: cover property (frameStart && readPend_r);
    c_reg_reset: cover property (regReset);
    c_frame_abort: cover property (syncRise && (state_r == CDL_RUN) && (pos_r != CDL_LAST_POS));
    c_power_write: cover property (wrStrobe_r && wrIdx_r == CDL_IDX_POWER);

endmodule : cdl_codec_link
